// file: design/tcc_pkg.sv
// constants for the cascadable 8-bit timer pair: register map, fields, codes
// assumes a 32-bit apb slave with one register per aligned word
package tcc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] TCC_IDX_LO_PERIOD = 8'h14;
  localparam logic [7:0] TCC_IDX_LO_PWIDTH = 8'h18;
  localparam logic [7:0] TCC_IDX_LO_CTRL = 8'h27;
  localparam logic [7:0] TCC_IDX_UP_PERIOD = 8'h15;
  localparam logic [7:0] TCC_IDX_UP_PWIDTH = 8'h19;
  localparam logic [7:0] TCC_IDX_UP_CTRL = 8'h28;
  localparam logic [7:0] TCC_IDX_CONFIG = 8'h30;
  localparam logic [7:0] TCC_IDX_STATUS = 8'h31;
  // reset values
  localparam logic [7:0] TCC_RST_TIMER_REG = 8'hFF;
  localparam logic [7:0] TCC_RST_CTRL = 8'h00;
  localparam logic [1:0] TCC_RST_CONFIG = 2'h0;
  // control register fields
  localparam int TCC_CTL_PRESET = 7;
  localparam int TCC_CTL_CLK_HI = 6;
  localparam int TCC_CTL_CLK_LO = 4;
  localparam int TCC_CTL_RUN = 3;
  localparam int TCC_CTL_MODE_HI = 2;
  // config register fields
  localparam int TCC_CFG_PRESCALER = 0;
  localparam int TCC_CFG_SLOW = 1;
  // mode codes
  localparam logic [2:0] TCC_M_TIMER = 3'h0;
  localparam logic [2:0] TCC_M_PDO = 3'h1;
  localparam logic [2:0] TCC_M_PWM = 3'h2;
  localparam logic [2:0] TCC_M_CASCADE = 3'h3;
  localparam logic [2:0] TCC_M_T16 = 3'h4;
  localparam logic [2:0] TCC_M_WARMUP = 3'h5;
  localparam logic [2:0] TCC_M_PWM16 = 3'h6;
  // clock select codes
  localparam logic [2:0] TCC_CK_SLOWEST = 3'h0;
  localparam logic [2:0] TCC_CK_FC128 = 3'h1;
  localparam logic [2:0] TCC_CK_FC32 = 3'h2;
  localparam logic [2:0] TCC_CK_FC8 = 3'h3;
  localparam logic [2:0] TCC_CK_FS = 3'h4;
  localparam logic [2:0] TCC_CK_FC2 = 3'h5;
  localparam logic [2:0] TCC_CK_FC = 3'h6;
  localparam logic [2:0] TCC_CK_PIN = 3'h7;
  // divider widths in bits
  localparam int TCC_DIV_BITS = 11;
  localparam int TCC_FS_DIV_BITS = 3;
  // address lsbs below the word index
  localparam int TCC_ADDR_LSB = 2;
endpackage

// file: design/tcc_div_if.sv
// divided clock enables shared from the top to the clock selectors
// assumes all enables are one-cycle pulses on pclk
`timescale 1ns/100ps
`default_nettype none
interface tcc_div_if;
  logic fc2;
  logic fc8;
  logic fc32;
  logic fc128;
  logic fc2048;
  logic fs1;
  logic fs8;
  modport src (output fc2, fc8, fc32, fc128, fc2048, fs1, fs8);
  modport sink (input fc2, fc8, fc32, fc128, fc2048, fs1, fs8);
endinterface
`default_nettype wire

// file: design/tcc_clk_sel.sv
// source clock selector for one timer channel, gives a count enable
// assumes the pin tick is already synchronised and edge detected
`timescale 1ns/100ps
`default_nettype none
module tcc_clk_sel (
  input wire logic [2:0] clock_sel,
  input wire logic prescaler_option,
  input wire logic slow_mode,
  input wire logic pin_tick,
  tcc_div_if.sink div,
  output logic tick
);
  import tcc_pkg::*;

  // slow operation leaves only the low clock paths and fc for warm-up
  always_comb begin
    tick = 1'b0;
    case (clock_sel)
      TCC_CK_SLOWEST: begin
        tick = (prescaler_option || slow_mode) ? div.fs8 : div.fc2048;
      end
      TCC_CK_FC128: tick = slow_mode ? 1'b0 : div.fc128;
      TCC_CK_FC32: tick = slow_mode ? 1'b0 : div.fc32;
      TCC_CK_FC8: tick = slow_mode ? 1'b0 : div.fc8;
      TCC_CK_FS: tick = div.fs1;
      TCC_CK_FC2: tick = slow_mode ? 1'b0 : div.fc2;
      TCC_CK_FC: tick = 1'b1;
      TCC_CK_PIN: tick = slow_mode ? 1'b0 : pin_tick;
      default: tick = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// file: design/tcc_timer.sv
// apb register layer and counters for a cascadable pair of 8-bit timers
// assumes pclk is the high-frequency clock; fs and the event pins are async
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module tcc_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_freq_clock,
  input wire logic lower_event_pin,
  input wire logic upper_event_pin,
  output logic lower_timer_out,
  output logic upper_timer_out,
  output logic lower_match,
  output logic upper_match
);
  import tcc_pkg::*;

  // per-channel software registers, counter and output state
  logic [7:0] ctl_q [2];
  logic [7:0] per_q [2];
  logic [7:0] pw_q [2];
  logic [7:0] pwsh_q [2];
  logic [7:0] cnt_q [2];
  logic [1:0] run_q;
  logic [1:0] ff_q;
  logic [1:0] match_q;

  // shared configuration, clock dividers and pin synchronisers
  logic [1:0] cfg_q;
  logic [TCC_DIV_BITS-1:0] div_q;
  logic [TCC_FS_DIV_BITS-1:0] fsdiv_q;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] pin_rise;

  // bus response registers
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // per-channel decisions, rebuilt every cycle from registered state
  logic [1:0] sel_tick;
  logic [1:0] run;
  logic [1:0] start;
  logic [1:0] inc;
  logic [1:0] clr;
  logic [1:0] tog;
  logic [1:0] reload;
  logic [1:0] hit;
  logic casc;
  logic [15:0] cnt16;
  logic [15:0] per16;
  logic [15:0] pw16;
  logic lo_wrap;

  // bus decode
  logic [7:0] idx;
  logic wr_done;
  logic mapped;
  logic [31:0] rd_d;
  logic [2:0] pins;

  // divided enables, shared by both clock selectors
  tcc_div_if div ();

  // word index and write strobe; refused addresses never land
  assign idx = paddr[TCC_ADDR_LSB+7:TCC_ADDR_LSB];
  assign wr_done = psel && penable && pready_q && pwrite && mapped;
  assign pins = {upper_event_pin, lower_event_pin, low_freq_clock};

  // async inputs pass two flops; the third stage only feeds edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // rising edges only; a pin held high counts once
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_edge
      assign pin_rise[p] = sync2_q[p] && !sync3_q[p];
    end
  endgenerate

  // free-running fc divider and fs/8 prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
      fsdiv_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
      if (pin_rise[0]) begin
        fsdiv_q <= fsdiv_q + 1'b1;
      end
    end
  end

  // enables fire once per divided period, on the all-ones count; fs1 on every fs rising edge
  assign div.fc2 = div_q[0];
  assign div.fc8 = &div_q[2:0];
  assign div.fc32 = &div_q[4:0];
  assign div.fc128 = &div_q[6:0];
  assign div.fc2048 = &div_q;
  assign div.fs1 = pin_rise[0];
  assign div.fs8 = pin_rise[0] && (&fsdiv_q);

  tcc_clk_sel u_sel_lo (
    .clock_sel(ctl_q[0][TCC_CTL_CLK_HI:TCC_CTL_CLK_LO]),
    .prescaler_option(cfg_q[TCC_CFG_PRESCALER]),
    .slow_mode(cfg_q[TCC_CFG_SLOW]),
    .pin_tick(pin_rise[1]),
    .div(div),
    .tick(sel_tick[0])
  );

  tcc_clk_sel u_sel_up (
    .clock_sel(ctl_q[1][TCC_CTL_CLK_HI:TCC_CTL_CLK_LO]),
    .prescaler_option(cfg_q[TCC_CFG_PRESCALER]),
    .slow_mode(cfg_q[TCC_CFG_SLOW]),
    .pin_tick(pin_rise[2]),
    .div(div),
    .tick(sel_tick[1])
  );

  // cascade needs lower mode 011 and an upper mode with its top bit set
  assign casc = (ctl_q[0][TCC_CTL_MODE_HI:0] == TCC_M_CASCADE) && ctl_q[1][TCC_CTL_MODE_HI];
  assign run[0] = casc ? ctl_q[1][TCC_CTL_RUN] : ctl_q[0][TCC_CTL_RUN];
  assign run[1] = ctl_q[1][TCC_CTL_RUN];
  assign start = run & ~run_q;
  assign cnt16 = {cnt_q[1], cnt_q[0]};
  assign per16 = {per_q[1], per_q[0]};
  assign pw16 = {pwsh_q[1], pwsh_q[0]};
  assign lo_wrap = sel_tick[0] && (cnt_q[0] == 8'hFF);

  // count, compare and toggle decisions for both channels
  always_comb begin
    logic [2:0] m;
    m = 3'h0;
    inc = 2'h0;
    clr = 2'h0;
    tog = 2'h0;
    reload = 2'h0;
    hit = 2'h0;
    for (int c = 0; c < 2; c++) begin
      m = ctl_q[c][TCC_CTL_MODE_HI:0];
      case (m)
        // timer and divider output: period+1 ticks per match
        TCC_M_TIMER, TCC_M_PDO: begin
          inc[c] = sel_tick[c];
          if (sel_tick[c] && cnt_q[c] == per_q[c]) begin
            clr[c] = 1'b1;
            hit[c] = 1'b1;
            tog[c] = (m == TCC_M_PDO);
          end
        end
        // pwm free-runs over the full byte; period end reloads
        TCC_M_PWM: begin
          inc[c] = sel_tick[c];
          tog[c] = sel_tick[c] && (cnt_q[c] == pwsh_q[c]);
          if (sel_tick[c] && cnt_q[c] == 8'hFF) begin
            reload[c] = 1'b1;
            hit[c] = 1'b1;
          end
        end
        // cascade halves and reserved codes are settled below
        default: inc[c] = 1'b0;
      endcase
    end
    if (casc) begin
      // upper byte counts lower overflow, own clock select ignored
      inc = {lo_wrap, sel_tick[0]};
      clr = 2'h0;
      tog = 2'h0;
      reload = 2'h0;
      hit = 2'h0;
      case (ctl_q[1][TCC_CTL_MODE_HI:0])
        // warm-up counts like the 16-bit timer
        TCC_M_T16, TCC_M_WARMUP: begin
          if (sel_tick[0] && cnt16 == per16) begin
            clr = 2'h3;
            hit[1] = 1'b1;
          end
        end
        // 16-bit waveform lands on the upper flip-flop
        TCC_M_PWM16: begin
          tog[1] = sel_tick[0] && (cnt16 == pw16);
          if (lo_wrap && cnt_q[1] == 8'hFF) begin
            reload = 2'h3;
            hit[1] = 1'b1;
          end
        end
        // upper 111 has no 16-bit meaning: hold both bytes
        default: inc = 2'h0;
      endcase
    end
  end

  // per-channel counter, output flip-flop and pulse-width shadow
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      logic preset;
      assign preset = (casc && g == 0) ? ctl_q[1][TCC_CTL_PRESET] : ctl_q[g][TCC_CTL_PRESET];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q[g] <= 8'h00;
          run_q[g] <= 1'b0;
          ff_q[g] <= 1'b0;
          match_q[g] <= 1'b0;
          pwsh_q[g] <= TCC_RST_TIMER_REG;
        end else begin
          run_q[g] <= run[g];
          match_q[g] <= run[g] && run_q[g] && hit[g];
          if (!run[g]) begin
            cnt_q[g] <= 8'h00;
          end else if (start[g]) begin
            cnt_q[g] <= 8'h00;
            ff_q[g] <= preset;
            pwsh_q[g] <= pw_q[g];
          end else begin
            if (clr[g]) begin
              cnt_q[g] <= 8'h00;
            end else if (inc[g]) begin
              cnt_q[g] <= cnt_q[g] + 8'h01;
            end
            // pwm restarts each period from the preset level
            if (reload[g]) begin
              ff_q[g] <= preset;
              pwsh_q[g] <= pw_q[g];
            end else if (tog[g]) begin
              ff_q[g] <= !ff_q[g];
            end
          end
        end
      end
    end
  endgenerate

  // software registers; a pulse-width write while running lands next period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_q[0] <= TCC_RST_TIMER_REG;
      pw_q[0] <= TCC_RST_TIMER_REG;
      ctl_q[0] <= TCC_RST_CTRL;
      per_q[1] <= TCC_RST_TIMER_REG;
      pw_q[1] <= TCC_RST_TIMER_REG;
      ctl_q[1] <= TCC_RST_CTRL;
      cfg_q <= TCC_RST_CONFIG;
    end else if (wr_done) begin
      case (idx)
        TCC_IDX_LO_PERIOD: per_q[0] <= pwdata[7:0];
        TCC_IDX_LO_PWIDTH: pw_q[0] <= pwdata[7:0];
        TCC_IDX_LO_CTRL: ctl_q[0] <= pwdata[7:0];
        TCC_IDX_UP_PERIOD: per_q[1] <= pwdata[7:0];
        TCC_IDX_UP_PWIDTH: pw_q[1] <= pwdata[7:0];
        TCC_IDX_UP_CTRL: ctl_q[1] <= pwdata[7:0];
        TCC_IDX_CONFIG: cfg_q <= pwdata[1:0];
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // read mux; unmapped addresses read zero and flag an error
  always_comb begin
    mapped = 1'b1;
    rd_d = 32'h0;
    case (idx)
      TCC_IDX_LO_PERIOD: rd_d[7:0] = per_q[0];
      TCC_IDX_LO_PWIDTH: rd_d[7:0] = pw_q[0];
      TCC_IDX_LO_CTRL: rd_d[7:0] = ctl_q[0];
      TCC_IDX_UP_PERIOD: rd_d[7:0] = per_q[1];
      TCC_IDX_UP_PWIDTH: rd_d[7:0] = pw_q[1];
      TCC_IDX_UP_CTRL: rd_d[7:0] = ctl_q[1];
      TCC_IDX_CONFIG: rd_d[1:0] = cfg_q;
      TCC_IDX_STATUS: rd_d[19:0] = {run_q, ff_q, cnt_q[1], cnt_q[0]};
      default: mapped = 1'b0;
    endcase
    if (paddr[TCC_ADDR_LSB-1:0] != 2'h0 || paddr[31:TCC_ADDR_LSB+8] != '0) begin
      mapped = 1'b0;
      rd_d = 32'h0;
    end
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped;
      if (psel && penable && !pready_q && !pwrite) begin
        prdata_q <= rd_d;
      end
    end
  end

  // every output straight from its flop
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign lower_timer_out = ff_q[0];
  assign upper_timer_out = ff_q[1];
  assign lower_match = match_q[0];
  assign upper_match = match_q[1];
endmodule
`default_nettype wire

// file: tb/tcc_sw_model.sv
// apb master standing in for the processor software
// assumes pclk from the bench and a slave that ends each access with pready
`timescale 1ns/100ps
`default_nettype none
module tcc_sw_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
  end
  // one transfer; the request holds until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show garbage, not the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// file: tb/tcc_timer_asserts.sv
// assertion checker for the timer pair, bound to its apb and timer ports
// assumes software changes fields only while a channel is stopped
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic lower_timer_out,
  input wire logic lower_match,
  input wire logic upper_match
);
  logic land;
  logic ok_q;
  logic [2:0] lo_h_q, up_h_q;
  logic [7:0] lo_ctl_q, up_ctl_q, lo_per_q;
  logic [9:0] gap_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign land = psel && penable && pready && pwrite;
  // shadows of landed writes; run history lets a late match drain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_ctl_q <= 8'h00;
      up_ctl_q <= 8'h00;
      lo_per_q <= 8'hFF;
      lo_h_q <= 3'h0;
      up_h_q <= 3'h0;
    end else begin
      lo_h_q <= {lo_h_q[1:0], lo_ctl_q[3]};
      up_h_q <= {up_h_q[1:0], up_ctl_q[3]};
      if (land && paddr == 32'h9C) lo_ctl_q <= pwdata[7:0];
      if (land && paddr == 32'hA0) up_ctl_q <= pwdata[7:0];
      if (land && paddr == 32'h50) lo_per_q <= pwdata[7:0];
    end
  end
  // cycles between lower matches; any write voids the measurement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 10'h0;
      ok_q <= 1'b0;
    end else begin
      gap_q <= lower_match ? 10'h1 : gap_q + 10'h1;
      ok_q <= !land && (lower_match || ok_q);
    end
  end
  chk_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not after one wait");
  chk_bad_addr: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  chk_ctl_read: assert property (pready && !pwrite && paddr == 32'h9C |-> prdata == {24'h0, lo_ctl_q})
    else $error("lower control readback wrong");
  chk_lo_stop: assert property (!lo_ctl_q[3] && lo_h_q == 3'h0 && lo_ctl_q[2:0] != 3'h3 |-> !lower_match)
    else $error("lower match while stopped");
  chk_up_stop: assert property (!up_ctl_q[3] && up_h_q == 3'h0 |-> !upper_match)
    else $error("upper match while stopped");
  chk_preset_load: assert property ($rose(lo_ctl_q[3]) && lo_ctl_q[2:0] == 3'h0 |-> ##3 lower_timer_out == lo_ctl_q[7])
    else $error("output not preset at start");
  chk_match_pulse: assert property (lower_match && lo_per_q != 8'h0 && lo_ctl_q[2:0] != 3'h3 |=> !lower_match)
    else $error("match longer than one cycle");
  chk_match_period: assert property (lower_match && ok_q && lo_ctl_q[6:0] == 7'h68 |-> gap_q == {2'h0, lo_per_q} + 10'h1)
    else $error("match spacing not period plus one");
  cov_cascade: cover property (upper_match && lo_ctl_q[2:0] == 3'h3);
  cov_refused: cover property (pready && pslverr);
  cov_pwm: cover property (lower_match && lo_ctl_q[2:0] == 3'h2);
endmodule
bind tcc_timer tcc_timer_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .lower_timer_out, .lower_match, .upper_match);
`default_nettype wire

// file: tb/test_cascadable_8bit_timer_control.sv
// self-checking bench for the cascadable timer pair
// assumes the apb master model drives every bus input
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module test_cascadable_8bit_timer_control;
  import tcc_pkg::*;
  // config, clock code, expected match spacing (0: never) with period 1
  localparam int CFG[14] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 2, 2, 2, 2, 2};
  localparam int CK[14] = '{0, 1, 2, 3, 4, 5, 6, 7, 0, 0, 4, 6, 1, 3};
  localparam int GAP[14] = '{4096, 256, 64, 16, 20, 4, 2, 12, 160, 160, 20, 2, 0, 0};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic low_freq_clock = 1'b0;
  logic lower_event_pin = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic lower_timer_out, upper_timer_out, lower_match, upper_match;
  logic [31:0] paddr, pwdata, prdata, rdat;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int g, h;
  tcc_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .low_freq_clock, .lower_event_pin, .upper_event_pin(lower_event_pin), .lower_timer_out, .upper_timer_out,
    .lower_match, .upper_match);
  tcc_sw_model u_sw (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // slow clock every 10 cycles, event pin every 6; hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    low_freq_clock <= (cyc % 10) < 5;
    lower_event_pin <= (cyc % 6) < 3;
    if (cyc == 60000) begin
      errors++;
      final_report();
    end
  end
  function automatic logic [31:0] ad(input logic [7:0] i);
    return {22'h0, i, 2'b00};
  endfunction
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    u_sw.xfer(1'b1, ad(i), {24'h0, d}, rdat, err);
  endtask
  task automatic rd(input logic [31:0] a);
    u_sw.xfer(1'b0, a, 32'h0, rdat, err);
  endtask
  // cycles between two matches, 0 if none comes
  task automatic gap_of(input logic up, output int gp);
    int n;
    n = 0;
    gp = 0;
    while ((up ? upper_match : lower_match) !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (n < 5000) begin
      @(posedge pclk);
      gp = 1;
      while ((up ? upper_match : lower_match) !== 1'b1 && gp < 5000) begin
        @(posedge pclk);
        gp++;
      end
    end
  endtask
  // high cycles of the lower output over one pwm period
  task automatic hi_of(output int hc);
    hc = 0;
    repeat (256) begin
      @(posedge pclk);
      hc += int'(lower_timer_out === 1'b1);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(ad(TCC_IDX_LO_PERIOD));
    `CHK("lo_period", 32'hFF, rdat)
    rd(ad(TCC_IDX_LO_PWIDTH));
    `CHK("lo_pwidth", 32'hFF, rdat)
    rd(ad(TCC_IDX_LO_CTRL));
    `CHK("lo_ctrl", 32'h0, rdat)
    rd(ad(TCC_IDX_UP_PWIDTH));
    `CHK("up_pwidth", 32'hFF, rdat)
    wr(TCC_IDX_LO_PWIDTH, 8'h5A);
    rd(ad(TCC_IDX_LO_PWIDTH));
    `CHK("lo_pwidth", 32'h5A, rdat)
    rd(32'h51);
    `CHK("unmapped", 33'h100000000, {err, rdat})
    u_sw.xfer(1'b1, 32'h51, 32'h77, rdat, err);
    `CHK("wr_refused", 1'b1, err)
    rd(ad(TCC_IDX_LO_PERIOD));
    `CHK("lo_period", 32'hFF, rdat)
    wr(TCC_IDX_LO_PERIOD, 8'h01);
    for (int i = 0; i < 14; i++) begin
      wr(TCC_IDX_CONFIG, 8'(CFG[i]));
      wr(TCC_IDX_LO_CTRL, {1'b0, 3'(CK[i]), 4'h8});
      gap_of(1'b0, g);
      `CHK("gap", GAP[i], g)
      wr(TCC_IDX_LO_CTRL, {1'b0, 3'(CK[i]), 4'h0});
    end
    wr(TCC_IDX_CONFIG, 8'h00);
    wr(TCC_IDX_LO_PERIOD, 8'hF0);
    wr(TCC_IDX_LO_CTRL, 8'hE8);
    repeat (20) @(posedge pclk);
    `CHK("lo_out", 1'b1, lower_timer_out)
    wr(TCC_IDX_LO_CTRL, 8'hE0);
    rd(ad(TCC_IDX_STATUS));
    `CHK("stopped", 9'h0, {rdat[18], rdat[7:0]})
    wr(TCC_IDX_LO_PWIDTH, 8'h10);
    wr(TCC_IDX_LO_CTRL, 8'h6A);
    repeat (600) @(posedge pclk);
    hi_of(h);
    wr(TCC_IDX_LO_PWIDTH, 8'h40);
    repeat (600) @(posedge pclk);
    hi_of(g);
    `CHK("pwm_duty", 48, h - g)
    wr(TCC_IDX_LO_CTRL, 8'h62);
    wr(TCC_IDX_LO_PERIOD, 8'h03);
    wr(TCC_IDX_UP_PERIOD, 8'h01);
    wr(TCC_IDX_LO_CTRL, 8'h63);
    wr(TCC_IDX_UP_CTRL, 8'h0C);
    gap_of(1'b1, g);
    `CHK("cascade_gap", 260, g)
    wr(TCC_IDX_UP_CTRL, 8'h04);
    wr(TCC_IDX_UP_CTRL, 8'h8D);
    gap_of(1'b1, g);
    `CHK("warmup_gap", 260, g)
    `CHK("casc_out", 2'h3, {upper_timer_out, lower_timer_out})
    wr(TCC_IDX_UP_CTRL, 8'h85);
    wr(TCC_IDX_UP_CTRL, 8'hE8);
    gap_of(1'b1, g);
    `CHK("up_gap", 2, g)
    `CHK("up_out", 1'b1, upper_timer_out)
    wr(TCC_IDX_UP_CTRL, 8'hE0);
    wr(TCC_IDX_LO_CTRL, 8'h69);
    repeat (4) @(posedge pclk);
    hi_of(h);
    `CHK("pdo_duty", 128, h)
    wr(TCC_IDX_LO_CTRL, 8'h61);
    final_report();
  end
endmodule
`default_nettype wire
